// [drop_counter_if.sv]
// carrier between the statistics bank and one saturating drop counter
// assumes both ends run on the switch core clock
interface drop_counter_if;
	logic        inc;   // one drop this cycle
	logic        clr;   // read-clear this cycle
	logic [31:0] count; // current count

	// bank side drives strobes, sees the count
	modport owner   (output inc, output clr, input count);
	// counter side
	modport counter (input inc, input clr, output count);
endinterface

// [drop_source_model.sv]
// behavioural buffer manager reporting drops to the statistics block
// assumes the bench calls its tasks; pins move 1 ns after clk_in rises
module drop_source_model (
	// core clock
	input  wire logic       clk_in,
	// drop reports
	output logic      [2:0] rate_drop_out,
	output logic            drop_event_out,
	output logic      [3:0] drop_reason_out,
	output logic      [1:0] drop_port_out
);
	timeunit 1ns;
	timeprecision 100ps;
	// quiet at time zero
	initial begin
		rate_drop_out   = 3'h0;
		drop_event_out  = 1'b0;
		drop_reason_out = 4'h0;
		drop_port_out   = 2'h0;
	end
	// rate drops on ports in sel, held n cycles back to back
	task automatic rate(input logic [2:0] sel, input int n);
		@(posedge clk_in) #1;
		rate_drop_out = sel;
		repeat (n - 1) @(posedge clk_in);
		@(posedge clk_in) #1;
		rate_drop_out = 3'h0;
	endtask
	// one event; fields turn to garbage once the pulse ends
	task automatic report(input logic [3:0] why, input logic [1:0] port);
		@(posedge clk_in) #1;
		drop_event_out  = 1'b1;
		drop_reason_out = why;
		drop_port_out   = port;
		@(posedge clk_in) #1;
		drop_event_out  = 1'b0;
		drop_reason_out = ~why;
		drop_port_out   = ~port;
	endtask
endmodule

// [drop_stats_pkg.sv]
// constants shared by the drop statistics block and its counter leaf
// assumes a single switch core clock; register numbers are word indexes
package drop_stats_pkg;

	// register numbers as seen on the management port (byte address = 4 * index)
	localparam logic [15:0] PORT0_RATE_DROP_COUNT_IDX = 16'h1c16;
	localparam logic [15:0] PORT1_RATE_DROP_COUNT_IDX = 16'h1c17;
	localparam logic [15:0] PORT2_RATE_DROP_COUNT_IDX = 16'h1c18;
	localparam logic [15:0] DROP_EVENT_IRQ_MASK_IDX   = 16'h1c20;
	localparam logic [15:0] DROP_EVENT_PENDING_IDX    = 16'h1c21;

	// geometry
	localparam int          NUM_PORTS  = 3;
	localparam int          COUNT_W    = 32;
	localparam logic [31:0] COUNT_MAX  = 32'hffff_ffff;
	localparam logic [31:0] COUNT_RST  = 32'h0000_0000;
	localparam logic [31:0] COUNT_ONE  = 32'h0000_0001;

	// mask register
	localparam int          MASK_BIT   = 0;
	localparam logic        MASK_RST   = 1'b1;

	// pending register field positions
	localparam int          A_VALID_BIT  = 0;
	localparam int          A_PORT_LSB   = 1;
	localparam int          A_REASON_LSB = 3;
	localparam int          B_PEND_BIT   = 7;
	localparam int          B_PORT_LSB   = 8;
	localparam int          B_REASON_LSB = 10;
	localparam logic [3:0]  REASON_RST   = 4'h0;
	localparam logic [1:0]  PORT_RST     = 2'h0;

	// drop reason codes
	localparam logic [3:0]  REASON_BCAST_LEVEL   = 4'h0;
	localparam logic [3:0]  REASON_RED           = 4'h1;
	localparam logic [3:0]  REASON_NO_BUFFER     = 4'h2;
	localparam logic [3:0]  REASON_NO_DESCRIPTOR = 4'h3;
	localparam logic [3:0]  REASON_NO_DEST_PORT  = 4'h4;
	localparam logic [3:0]  REASON_RX_ERROR      = 4'h5;
	localparam logic [3:0]  REASON_BUFFER_LEVEL  = 4'h6;
	localparam logic [3:0]  REASON_YELLOW        = 4'h9;

	// source port codes
	localparam logic [1:0]  SRC_PORT0 = 2'h0;
	localparam logic [1:0]  SRC_PORT1 = 2'h1;
	localparam logic [1:0]  SRC_PORT2 = 2'h2;

endpackage

// [sat_drop_counter.sv]
// one 32-bit saturating, clear-on-read drop counter
// assumes inc and clr come from logic on the same clock
module sat_drop_counter
	import drop_stats_pkg::*;
(
	// clock, reset, enable
	input  wire logic clk_in,
	input  wire logic resetn_in,
	input  wire logic ce_in,
	// strobes in, count out
	drop_counter_if.counter cnt
);

	logic [COUNT_W-1:0] count_ff;     // the counter itself
	logic [COUNT_W-1:0] nxt_count;    // next value
	logic               at_max;       // saturated

	assign at_max    = (count_ff == COUNT_MAX);
	// a clear still keeps a drop of the same cycle
	assign nxt_count = cnt.clr ? (cnt.inc ? COUNT_ONE : COUNT_RST) :
	                   (cnt.inc && !at_max) ? count_ff + COUNT_ONE :
	                   count_ff;
	assign cnt.count = count_ff;

	// counter register, zero after reset
	always_ff @(posedge clk_in or negedge resetn_in) begin
		if (!resetn_in) begin
			count_ff <= COUNT_RST;
		end else if (ce_in) begin
			count_ff <= nxt_count;
		end
	end

endmodule

// [switch_drop_stats_and_events.sv]
// drop statistics and drop event record of the switch buffer manager
// assumes the management port decoder gives one-cycle read and write strobes
// with a register number, and the buffer manager gives one-cycle drop pulses,
// all on the switch core clock
// counters saturate rather than wrap, so a late read never shows a small count

// Functional notes
// - per-port 32-bit count of ingress rate drops
// - counter read returns value, then clears; reset zero
// - counter saturates at all ones
// - mask bit resets to 1, masks events
// - masking never stops event capture
// - two event slots: reason, port, valid
// - reasons 0000, 0100, 0110 for lookup/level
// - reasons 0001 red, 1001 yellow
// - reasons 0010, 0011, 0101 for resources/errors
// - port code 00,01,10; 11 reserved
// - slot B flag bit 7, fields 13:8, clear-on-read
// - slot A flag bit 0, fields 6:1
module switch_drop_stats_and_events
	import drop_stats_pkg::*;
(
	// clock, reset, enable
	input  wire logic        clk_in,
	input  wire logic        resetn_in,
	input  wire logic        ce_in,
	// register access from the management port (register number, not byte address)
	input  wire logic        reg_rd_in,
	input  wire logic        reg_wr_in,
	input  wire logic [15:0] reg_addr_in,
	input  wire logic [31:0] reg_wdata_in,
	output logic      [31:0] reg_rdata_out,
	output logic             reg_rvalid_out,
	// ingress rate drops, one pulse per dropped packet per port
	input  wire logic [2:0]  rate_drop_in,
	// drop events from buffer manager
	input  wire logic        drop_event_in,
	input  wire logic [3:0]  drop_reason_in,
	input  wire logic [1:0]  drop_port_in,
	// interrupt request to the system interrupt logic
	output logic             irq_out
);

	// address decode
	logic                     hit_count_any;  // one of the counters
	logic [NUM_PORTS-1:0]     hit_count;      // per-port counter hit
	logic                     hit_mask;       // mask register hit
	logic                     hit_pend;       // pending register hit
	logic                     rd_go;          // read taken this cycle
	logic                     wr_go;          // write taken this cycle

	// counter bank
	logic [COUNT_W-1:0]       count_val [NUM_PORTS]; // per-port counts

	// mask and event slots
	logic                     mask_ff;        // interrupt mask
	logic                     a_valid_ff;     // slot A valid
	logic [3:0]               a_reason_ff;    // slot A reason
	logic [1:0]               a_port_ff;      // slot A port
	logic                     b_pend_ff;      // slot B pending
	logic [3:0]               b_reason_ff;    // slot B reason
	logic [1:0]               b_port_ff;      // slot B port

	// slot update terms
	logic                     pend_clr;       // pending register read
	logic                     a_free;         // slot A free after any clear
	logic                     b_free;         // slot B free after any clear
	logic                     load_a;         // event goes to A
	logic                     load_b;         // event goes to B
	logic                     nxt_a_valid;    // next slot A flag
	logic                     nxt_b_pend;     // next slot B flag

	// read path
	logic [31:0]              pend_word;      // packed pending register
	logic [31:0]              mask_word;      // packed mask register
	logic [31:0]              count_word;     // selected counter
	logic [31:0]              nxt_rdata;      // next read data

	// strobes qualified by the clock enable
	assign rd_go = reg_rd_in && ce_in;
	assign wr_go = reg_wr_in && ce_in;

	// register number decode, host byte address is already divided by four
	assign hit_count[0]  = (reg_addr_in == PORT0_RATE_DROP_COUNT_IDX);
	assign hit_count[1]  = (reg_addr_in == PORT1_RATE_DROP_COUNT_IDX);
	assign hit_count[2]  = (reg_addr_in == PORT2_RATE_DROP_COUNT_IDX);
	assign hit_count_any = |hit_count;
	assign hit_mask      = (reg_addr_in == DROP_EVENT_IRQ_MASK_IDX);
	assign hit_pend      = (reg_addr_in == DROP_EVENT_PENDING_IDX);

	// one saturating counter per port
	genvar p;
	generate
		for (p = 0; p < NUM_PORTS; p++) begin : g_port
			drop_counter_if cif ();

			// count every rate drop on this port
			assign cif.inc = rate_drop_in[p];
			// clear after a read of this counter
			assign cif.clr = rd_go && hit_count[p];
			assign count_val[p] = cif.count;

			sat_drop_counter u_cnt (
				.clk_in    (clk_in),
				.resetn_in (resetn_in),
				.ce_in     (ce_in),
				.cnt       (cif.owner)
			);
		end
	endgenerate

	// reading the pending register clears both slots
	assign pend_clr = rd_go && hit_pend;

	// slot occupancy as it will be once a read-clear takes effect,
	// so an event landing with the read is kept, not lost
	assign a_free = !a_valid_ff || pend_clr;
	assign b_free = !b_pend_ff || pend_clr;

	// capture ignores the mask; A first, B next, otherwise not recorded
	assign load_a = drop_event_in && a_free;
	assign load_b = drop_event_in && !a_free && b_free;

	// flag next values, set wins over clear
	assign nxt_a_valid = load_a || (a_valid_ff && !pend_clr);
	assign nxt_b_pend  = load_b || (b_pend_ff && !pend_clr);

	// mask register, bit 0 only
	always_ff @(posedge clk_in or negedge resetn_in) begin
		if (!resetn_in) begin
			mask_ff <= MASK_RST;
		end else if (wr_go && hit_mask) begin
			mask_ff <= reg_wdata_in[MASK_BIT];
		end
	end

	// slot A: reason and port kept as reported, code table in the package
	always_ff @(posedge clk_in or negedge resetn_in) begin
		if (!resetn_in) begin
			a_valid_ff  <= 1'b0;
			a_reason_ff <= REASON_RST;
			a_port_ff   <= PORT_RST;
		end else if (ce_in) begin
			a_valid_ff <= nxt_a_valid;
			if (load_a) begin
				a_reason_ff <= drop_reason_in;
				a_port_ff   <= drop_port_in;
			end else if (pend_clr) begin
				a_reason_ff <= REASON_RST;
				a_port_ff   <= PORT_RST;
			end
		end
	end

	// slot B: same layout, filled only while A is occupied
	always_ff @(posedge clk_in or negedge resetn_in) begin
		if (!resetn_in) begin
			b_pend_ff   <= 1'b0;
			b_reason_ff <= REASON_RST;
			b_port_ff   <= PORT_RST;
		end else if (ce_in) begin
			b_pend_ff <= nxt_b_pend;
			if (load_b) begin
				b_reason_ff <= drop_reason_in;
				b_port_ff   <= drop_port_in;
			end else if (pend_clr) begin
				b_reason_ff <= REASON_RST;
				b_port_ff   <= PORT_RST;
			end
		end
	end

	// pending register image; reserved bits read zero
	always_comb begin
		pend_word = 32'h0000_0000;
		pend_word[A_VALID_BIT]                  = a_valid_ff;
		pend_word[A_PORT_LSB +: 2]              = a_port_ff;
		pend_word[A_REASON_LSB +: 4]            = a_reason_ff;
		pend_word[B_PEND_BIT]                   = b_pend_ff;
		pend_word[B_PORT_LSB +: 2]              = b_port_ff;
		pend_word[B_REASON_LSB +: 4]            = b_reason_ff;
	end

	// mask register image
	always_comb begin
		mask_word           = 32'h0000_0000;
		mask_word[MASK_BIT] = mask_ff;
	end

	// counter selection, zero when no counter hit
	always_comb begin
		count_word = 32'h0000_0000;
		for (int i = 0; i < NUM_PORTS; i++) begin
			if (hit_count[i]) begin
				count_word = count_val[i];
			end
		end
	end

	// read mux; unmapped numbers read as zero
	assign nxt_rdata = hit_count_any ? count_word :
	                   hit_mask      ? mask_word  :
	                   hit_pend      ? pend_word  :
	                   32'h0000_0000;

	// read data and its valid pulse, one cycle after the strobe
	always_ff @(posedge clk_in or negedge resetn_in) begin
		if (!resetn_in) begin
			reg_rdata_out  <= 32'h0000_0000;
			reg_rvalid_out <= 1'b0;
		end else if (ce_in) begin
			reg_rvalid_out <= reg_rd_in;
			if (reg_rd_in) begin
				reg_rdata_out <= nxt_rdata;
			end
		end
	end

	// interrupt: either slot occupied and mask clear
	assign irq_out = (a_valid_ff || b_pend_ff) && !mask_ff;

endmodule

// [switch_drop_stats_and_events_monitor.sv]
// port assertions for the drop statistics and event block
// assumes it is bound into switch_drop_stats_and_events
module switch_drop_stats_and_events_monitor
	import drop_stats_pkg::*;
(
	// clock, reset, enable
	input wire logic        clk_in,
	input wire logic        resetn_in,
	input wire logic        ce_in,
	// register port
	input wire logic        reg_rd_in,
	input wire logic        reg_wr_in,
	input wire logic [15:0] reg_addr_in,
	input wire logic [31:0] reg_wdata_in,
	input wire logic [31:0] reg_rdata_out,
	input wire logic        reg_rvalid_out,
	// drop reports
	input wire logic [2:0]  rate_drop_in,
	input wire logic        drop_event_in,
	input wire logic [3:0]  drop_reason_in,
	input wire logic [1:0]  drop_port_in,
	// interrupt
	input wire logic        irq_out
);
	// accepted strobes and decoded targets
	wire rd   = ce_in && reg_rd_in;
	wire ev   = ce_in && drop_event_in;
	wire rd0  = rd && reg_addr_in == PORT0_RATE_DROP_COUNT_IDX;
	wire rdp  = rd && reg_addr_in == DROP_EVENT_PENDING_IDX;
	wire rdm  = rd && reg_addr_in == DROP_EVENT_IRQ_MASK_IDX;
	wire wrm  = ce_in && reg_wr_in && reg_addr_in == DROP_EVENT_IRQ_MASK_IDX;
	wire hit  = reg_addr_in inside {PORT0_RATE_DROP_COUNT_IDX, PORT1_RATE_DROP_COUNT_IDX,
		PORT2_RATE_DROP_COUNT_IDX, DROP_EVENT_IRQ_MASK_IDX, DROP_EVENT_PENDING_IDX};
	// one clock domain throughout
	default clocking cb @(posedge clk_in); endclocking
	default disable iff (!resetn_in);
	AST_RVALID: assert property (rd |=> reg_rvalid_out)
		else $error("read not answered");
	AST_RDATA_HOLD: assert property (!rd |=> $stable(reg_rdata_out))
		else $error("read data moved without a read");
	AST_UNMAPPED: assert property (rd && !hit |=> reg_rdata_out == 32'h0000_0000)
		else $error("unmapped read not zero");
	AST_COUNT_CLEAR: assert property ((rd0 && !rate_drop_in[0]) ##1 !rate_drop_in[0] ##1 rd0
		|=> reg_rdata_out == COUNT_RST) else $error("counter not cleared by read");
	AST_MASK_RW: assert property (wrm ##1 !wrm ##1 (rdm && !wrm)
		|=> reg_rdata_out == {31'h0000_0000, $past(reg_wdata_in[0], 3)})
		else $error("mask readback wrong");
	AST_MASK_IRQ: assert property (wrm && reg_wdata_in[0] |=> !irq_out)
		else $error("irq while masked");
	AST_IRQ_CAUSE: assert property ($rose(irq_out) |-> $past(wrm || ev))
		else $error("irq rose without cause");
	AST_PEND_CLEAR: assert property (rdp && !drop_event_in |=> !irq_out)
		else $error("irq after status cleared");
	AST_SLOT_A: assert property ((rdp && !drop_event_in) ##1 !ev ##1 (ev && !rdp) ##1 !rdp
		##1 rdp |=> reg_rdata_out[6:0] == {$past(drop_reason_in, 3), $past(drop_port_in, 3), 1'b1})
		else $error("slot A record wrong");
	// main scenarios reached
	COV_IRQ: cover property ($rose(irq_out));
	COV_SLOT_B: cover property (reg_rvalid_out && reg_rdata_out[7]);
	COV_SET_WINS: cover property (rd0 && rate_drop_in[0]);
endmodule

bind switch_drop_stats_and_events switch_drop_stats_and_events_monitor
	switch_drop_stats_and_events_monitor_i (.clk_in, .resetn_in, .ce_in, .reg_rd_in, .reg_wr_in,
	.reg_addr_in, .reg_wdata_in, .reg_rdata_out, .reg_rvalid_out, .rate_drop_in,
	.drop_event_in, .drop_reason_in, .drop_port_in, .irq_out);

// [test_switch_drop_stats_and_events.sv]
// self-checking bench for the drop statistics and event block
// assumes the package, counter leaf, carrier and model are compiled first
module test_switch_drop_stats_and_events import drop_stats_pkg::*;;
	timeunit 1ns;
	timeprecision 100ps;
	// design pins
	logic        clk_in, resetn_in, ce_in, reg_rd_in, reg_wr_in, irq_out, reg_rvalid_out;
	logic [15:0] reg_addr_in;
	logic [31:0] reg_wdata_in, reg_rdata_out;
	logic [2:0]  rate_drop_in;
	logic        drop_event_in;
	logic [3:0]  drop_reason_in;
	logic [1:0]  drop_port_in;
	int          fails, n_tests;
	localparam logic [15:0] C0 = PORT0_RATE_DROP_COUNT_IDX;
	localparam logic [15:0] MK = DROP_EVENT_IRQ_MASK_IDX;
	localparam logic [15:0] PD = DROP_EVENT_PENDING_IDX;
	switch_drop_stats_and_events switch_drop_stats_and_events_i (.clk_in, .resetn_in, .ce_in,
		.reg_rd_in, .reg_wr_in, .reg_addr_in, .reg_wdata_in, .reg_rdata_out, .reg_rvalid_out,
		.rate_drop_in, .drop_event_in, .drop_reason_in, .drop_port_in, .irq_out);
	drop_source_model drop_source_model_i (.clk_in, .rate_drop_out(rate_drop_in),
		.drop_event_out(drop_event_in), .drop_reason_out(drop_reason_in),
		.drop_port_out(drop_port_in));
	// 50 ns clock
	initial begin
		clk_in = 1'b0;
		forever #25 clk_in = ~clk_in;
	end
	// verdict and end of run
	task automatic finish_test();
		if (fails == 0 && n_tests > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		n_tests++;
		if (got !== exp) begin
			fails++;
			$display("wrong value at %0t: got %h want %h", $time, got, exp);
		end
	endtask
	// one-cycle write strobe
	task automatic wr(input logic [15:0] a, input logic [31:0] d);
		@(posedge clk_in) #1;
		reg_wr_in    = 1'b1;
		reg_addr_in  = a;
		reg_wdata_in = d;
		@(posedge clk_in) #1;
		reg_wr_in    = 1'b0;
	endtask
	// one-cycle read strobe, bounded wait for the answer, then compare
	task automatic rdchk(input logic [15:0] a, input logic [31:0] exp);
		int i;
		@(posedge clk_in) #1;
		reg_rd_in   = 1'b1;
		reg_addr_in = a;
		@(posedge clk_in) #1;
		reg_rd_in   = 1'b0;
		for (i = 0; i < 4 && reg_rvalid_out !== 1'b1; i++)
			@(posedge clk_in) #1;
		if (i == 4) begin
			fails++;
			finish_test();
		end
		chk(reg_rdata_out, exp);
	endtask
	// reset values and an unmapped number
	task automatic t_reset();
		for (int p = 0; p < NUM_PORTS; p++)
			rdchk(C0 + 16'(p), COUNT_RST);
		rdchk(MK, 32'h0000_0001);
		rdchk(16'h1c19, 32'h0000_0000);
	endtask
	// per-port counts, read clear, drop in the read cycle survives
	task automatic t_counts();
		drop_source_model_i.rate(3'h7, 3);
		drop_source_model_i.rate(3'h2, 2);
		drop_source_model_i.rate(3'h4, 1);
		rdchk(C0, 32'h0000_0003);
		rdchk(C0 + 16'h0001, 32'h0000_0005);
		rdchk(C0 + 16'h0002, 32'h0000_0004);
		fork
			rdchk(C0, COUNT_RST);
			drop_source_model_i.rate(3'h1, 1);
		join
		rdchk(C0, COUNT_ONE);
		rdchk(C0, COUNT_RST);
	endtask
	// masked event still recorded, then unmask
	task automatic t_masked();
		rdchk(PD, 32'h0000_0000);
		drop_source_model_i.report(REASON_RED, SRC_PORT2);
		chk(32'(irq_out), 32'h0000_0000);
		rdchk(PD, 32'h0000_000d);
		wr(MK, 32'h0000_0000);
		rdchk(MK, 32'h0000_0000);
	endtask
	// every reason through slots A and B, third event lost
	task automatic t_slots();
		logic [3:0] code [8];
		code = '{REASON_BCAST_LEVEL, REASON_RED, REASON_NO_BUFFER, REASON_NO_DESCRIPTOR,
			REASON_NO_DEST_PORT, REASON_RX_ERROR, REASON_BUFFER_LEVEL, REASON_YELLOW};
		for (int i = 0; i < 8; i += 2) begin
			drop_source_model_i.report(code[i], 2'(i % 3));
			chk(32'(irq_out), 32'h0000_0001);
			drop_source_model_i.report(code[i+1], 2'((i + 1) % 3));
			drop_source_model_i.report(4'hf, 2'h3);
			rdchk(PD, {18'h0_0000, code[i+1], 2'((i + 1) % 3), 1'b1, code[i], 2'(i % 3),
				1'b1});
			chk(32'(irq_out), 32'h0000_0000);
			rdchk(PD, 32'h0000_0000);
		end
	endtask
	// mask again, then frozen strobes while disabled
	task automatic t_ce();
		drop_source_model_i.report(REASON_RED, SRC_PORT0);
		wr(MK, 32'h0000_0001);
		chk(32'(irq_out), 32'h0000_0000);
		@(posedge clk_in) #1;
		ce_in = 1'b0;
		fork
			drop_source_model_i.rate(3'h1, 2);
			wr(MK, 32'h0000_0000);
		join
		@(posedge clk_in) #1;
		ce_in = 1'b1;
		rdchk(C0, COUNT_RST);
		rdchk(MK, 32'h0000_0001);
	endtask
	// pending read and new event in one cycle: event survives in slot A
	task automatic t_pend_race();
		fork
			rdchk(PD, 32'h0000_0009);
			drop_source_model_i.report(REASON_YELLOW, SRC_PORT1);
		join
		rdchk(PD, 32'h0000_004b);
		rdchk(PD, 32'h0000_0000);
	endtask
	// main sequence
	initial begin
		fails        = 0;
		n_tests      = 0;
		resetn_in    = 1'b0;
		ce_in        = 1'b1;
		reg_rd_in    = 1'b0;
		reg_wr_in    = 1'b0;
		reg_addr_in  = 16'h0000;
		reg_wdata_in = 32'h0000_0000;
		repeat (4) @(posedge clk_in);
		#1 resetn_in = 1'b1;
		t_reset();
		t_counts();
		t_masked();
		t_slots();
		t_ce();
		t_pend_race();
		finish_test();
	end
endmodule
